// ### core/wdrt_consts.vh
// constants for the watchdog reset timer: offsets, fields, resets, timing
`ifndef WDRT_CONSTS_VH
`define WDRT_CONSTS_VH

// register offsets on the plain register port
`define WDRT_ADDR_CTL         8'h00
`define WDRT_ADDR_CFG         8'h01
`define WDRT_ADDR_IEN         8'h02
`define WDRT_ADDR_GIE         8'h03
`define WDRT_ADDR_TA          8'h04

// control register fields
`define WDRT_CTL_RUN          7
`define WDRT_CTL_CLR          6
`define WDRT_CTL_TF           5
`define WDRT_CTL_LPSEL        4
`define WDRT_CTL_RF           3
`define WDRT_CTL_PS_HI        2
`define WDRT_CTL_PS_LO        0

// configuration byte fields and behaviour codes
`define WDRT_CFG_BEH_HI       7
`define WDRT_CFG_BEH_LO       4
`define WDRT_BEH_GP           4'hF
`define WDRT_BEH_HALT_LP      4'h5

// interrupt enable bit positions
`define WDRT_IEN_BIT          4
`define WDRT_GIE_BIT          7

// reset values
`define WDRT_CFG_RESET        8'hFF
`define WDRT_PS_POR           3'h7

// timed access unlock keys and window
`define WDRT_TA_KEY1          8'hAA
`define WDRT_TA_KEY2          8'h55
`define WDRT_TA_OPEN_CYC      3'h4

// timing: system clock 250 MHz, slow oscillator 10 kHz
`define WDRT_CLK_PERIOD_NS    4
`define WDRT_OSC_PERIOD_NS    100000
// slow period over clock period, sized for the 16-bit divider
`define WDRT_OSC_TICK_CYC     16'h61A8
`define WDRT_INTERVAL_TICKS   64
`define WDRT_GRACE_TICKS      512
// last counts at counter width: interval 64, grace 512
`define WDRT_LAST_COUNT       6'h3F
`define WDRT_LAST_GRACE       10'h1FF

`endif

// ### core/wdrt_prescaler.v
// selectable divider chain feeding the watchdog interval counter
`timescale 1ns/1ns
module wdrt_prescaler
(
    input  wire       i_clk,
    input  wire       i_reset_n,
    input  wire       i_enable,
    input  wire       i_clear,
    input  wire [2:0] i_sel,
    output wire       o_tick
);

    reg  [7:0] cnt_reg;
    reg  [7:0] cnt_next;
    reg  [7:0] limit;

    // divide factor minus one
    always @*
    begin
        case (i_sel)
            3'h0:    limit = 8'h00;
            3'h1:    limit = 8'h03;
            3'h2:    limit = 8'h07;
            3'h3:    limit = 8'h0F;
            3'h4:    limit = 8'h1F;
            3'h5:    limit = 8'h3F;
            3'h6:    limit = 8'h7F;
            default: limit = 8'hFF;
        endcase
    end

    assign o_tick = i_enable & ~i_clear & (cnt_reg >= limit);

    always @*
    begin
        cnt_next = cnt_reg;
        if (i_clear)
            cnt_next = 8'h00;
        else if (o_tick)
            cnt_next = 8'h00;
        else if (i_enable)
            cnt_next = cnt_reg + 8'h01;
    end

    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            cnt_reg <= 8'h00;
        else
            cnt_reg <= cnt_next;
    end

endmodule

// ### core/wdrt_timer.v
// watchdog reset timer / general purpose timer with timed-access control
// Summary of operation
// - config bits 7:4 equal 1111 select timer
// - 0101: reset timer, halts in low power
// - other codes: reset timer, runs in low power
// - counter clocked by divided slow oscillator
// - time-out after 64 prescaled clocks
// - prescale codes divide 1,4,8,...,256
// - time-out wakes system, interrupt when enabled
// - time-out sets flag; irq needs both enables
// - 512 oscillator clocks grace, then device reset
// - writing clear bit resets counter, self-clears
// - reset timer needs no run bit; power-on config selects timer
// - reset flag set by watchdog, kept except power-on
// - reset mode ignores run and low-power select
// - timer mode: run bit starts, keeps counting
// - clear bit reads one until clear finishes
// - timer mode: select bit decides low-power counting
// - prescale all ones at power-on, else kept
`timescale 1ns/1ns
`include "wdrt_consts.vh"
module wdrt_timer
#(
    parameter [15:0] OSC_TICK_CYC = `WDRT_OSC_TICK_CYC
)
(
    input  wire       i_clk,
    input  wire       i_reset_n,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    input  wire       i_lowpower,
    input  wire       i_other_reset,
    output wire [7:0] o_rdata,
    output wire       o_wd_reset,
    output wire       o_wake,
    output wire       o_irq_req
);

    localparam [5:0] LAST_COUNT = `WDRT_LAST_COUNT;
    localparam [9:0] LAST_GRACE = `WDRT_LAST_GRACE;

    // slow oscillator tick generation
    reg  [15:0] osc_cnt_reg;
    reg         osc_tick_reg;

    // control register bits
    reg         run_reg;
    reg         clr_reg;
    reg         tf_reg;
    reg         lpsel_reg;
    reg         rf_reg;
    reg  [2:0]  ps_reg;
    reg         run_next;
    reg         clr_next;
    reg         tf_next;
    reg         lpsel_next;
    reg         rf_next;
    reg  [2:0]  ps_next;

    // other software registers
    reg  [7:0]  cfg_reg;
    reg         ien_reg;
    reg         gie_reg;

    // timed access
    reg         ta_stage_reg;
    reg  [2:0]  ta_open_reg;
    reg         ta_stage_next;
    reg  [2:0]  ta_open_next;

    // counting state
    reg  [5:0]  wd_cnt_reg;
    reg  [5:0]  wd_cnt_next;
    reg         grace_reg;
    reg         grace_next;
    reg  [9:0]  grace_cnt_reg;
    reg  [9:0]  grace_cnt_next;

    // output flops
    reg  [7:0]  rdata_reg;
    reg         wd_reset_reg;
    reg         wake_reg;
    reg         irq_reg;

    wire        gp_mode;
    wire        halt_lp_mode;
    wire        count_en;
    wire        pre_enable;
    wire        clear_now;
    wire        scaled_tick;
    wire        timeout_evt;
    wire        grace_done;
    wire        soft_reset;
    wire        wr_ctl;
    wire        wr_ta;
    wire        ctl_open;
    wire [7:0]  ctl_read;

    assign gp_mode      = (cfg_reg[`WDRT_CFG_BEH_HI:`WDRT_CFG_BEH_LO] == `WDRT_BEH_GP);
    assign halt_lp_mode = (cfg_reg[`WDRT_CFG_BEH_HI:`WDRT_CFG_BEH_LO] == `WDRT_BEH_HALT_LP);

    // count enable per behaviour
    assign count_en = gp_mode ? (run_reg & (~i_lowpower | lpsel_reg)) :
                      halt_lp_mode ? ~i_lowpower :
                      1'b1;

    // a pending clear completes on the next oscillator tick
    assign clear_now  = osc_tick_reg & clr_reg;
    assign pre_enable = osc_tick_reg & count_en;

    wdrt_prescaler u_prescaler
    (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_enable  (pre_enable),
        .i_clear   (clear_now | soft_reset),
        .i_sel     (ps_reg),
        .o_tick    (scaled_tick)
    );

    assign timeout_evt = scaled_tick & (wd_cnt_reg == LAST_COUNT);
    assign grace_done  = grace_reg & pre_enable & ~clr_reg &
                         (grace_cnt_reg == LAST_GRACE);
    assign soft_reset  = i_other_reset | wd_reset_reg;

    assign wr_ctl   = i_wr & (i_addr == `WDRT_ADDR_CTL);
    assign wr_ta    = i_wr & (i_addr == `WDRT_ADDR_TA);
    assign ctl_open = (ta_open_reg != 3'h0);

    assign ctl_read = {run_reg, clr_reg, tf_reg, lpsel_reg, rf_reg, ps_reg};

    // slow oscillator tick divider
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            osc_cnt_reg  <= 16'h0000;
            osc_tick_reg <= 1'b0;
        end
        else if (osc_cnt_reg >= OSC_TICK_CYC - 16'h0001)
        begin
            osc_cnt_reg  <= 16'h0000;
            osc_tick_reg <= 1'b1;
        end
        else
        begin
            osc_cnt_reg  <= osc_cnt_reg + 16'h0001;
            osc_tick_reg <= 1'b0;
        end
    end

    // timed access unlock sequence
    always @*
    begin
        ta_stage_next = ta_stage_reg;
        ta_open_next  = ta_open_reg;
        if (ctl_open)
            ta_open_next = ta_open_reg - 3'h1;
        if (wr_ctl)
            ta_open_next = 3'h0;
        if (wr_ta)
        begin
            if (ta_stage_reg && i_wdata == `WDRT_TA_KEY2)
            begin
                ta_stage_next = 1'b0;
                ta_open_next  = `WDRT_TA_OPEN_CYC;
            end
            else
                ta_stage_next = (i_wdata == `WDRT_TA_KEY1);
        end
        else if (i_wr)
            ta_stage_next = 1'b0;
    end

    // control register next values
    always @*
    begin
        run_next   = run_reg;
        clr_next   = clr_reg;
        tf_next    = tf_reg;
        lpsel_next = lpsel_reg;
        rf_next    = rf_reg;
        ps_next    = ps_reg;
        if (clear_now)
            clr_next = 1'b0;
        if (wr_ctl && ctl_open)
        begin
            run_next   = i_wdata[`WDRT_CTL_RUN];
            tf_next    = i_wdata[`WDRT_CTL_TF];
            lpsel_next = i_wdata[`WDRT_CTL_LPSEL];
            rf_next    = i_wdata[`WDRT_CTL_RF];
            ps_next    = i_wdata[`WDRT_CTL_PS_HI:`WDRT_CTL_PS_LO];
            if (i_wdata[`WDRT_CTL_CLR])
                clr_next = 1'b1;
        end
        // hardware set wins over software clear
        if (timeout_evt)
            tf_next = 1'b1;
        if (soft_reset)
        begin
            run_next   = 1'b0;
            clr_next   = 1'b0;
            tf_next    = 1'b0;
            lpsel_next = 1'b0;
            if (wd_reset_reg)
                rf_next = 1'b1;
            ps_next    = ps_reg;
        end
    end

    // interval and grace counters
    always @*
    begin
        wd_cnt_next    = wd_cnt_reg;
        grace_next     = grace_reg;
        grace_cnt_next = grace_cnt_reg;
        if (scaled_tick)
            wd_cnt_next = wd_cnt_reg + 6'h01;
        if (timeout_evt && !gp_mode && !grace_reg)
        begin
            grace_next     = 1'b1;
            grace_cnt_next = 10'h000;
        end
        else if (grace_reg && pre_enable)
            grace_cnt_next = grace_cnt_reg + 10'h001;
        if (gp_mode)
            grace_next = 1'b0;
        if (clear_now)
        begin
            wd_cnt_next    = 6'h00;
            grace_next     = 1'b0;
            grace_cnt_next = 10'h000;
        end
        if (soft_reset || grace_done)
        begin
            wd_cnt_next    = 6'h00;
            grace_next     = 1'b0;
            grace_cnt_next = 10'h000;
        end
    end

    // sequential state
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            run_reg       <= 1'b0;
            clr_reg       <= 1'b0;
            tf_reg        <= 1'b0;
            lpsel_reg     <= 1'b0;
            rf_reg        <= 1'b0;
            ps_reg        <= `WDRT_PS_POR;
            ta_stage_reg  <= 1'b0;
            ta_open_reg   <= 3'h0;
            wd_cnt_reg    <= 6'h00;
            grace_reg     <= 1'b0;
            grace_cnt_reg <= 10'h000;
        end
        else
        begin
            run_reg       <= run_next;
            clr_reg       <= clr_next;
            tf_reg        <= tf_next;
            lpsel_reg     <= lpsel_next;
            rf_reg        <= rf_next;
            ps_reg        <= ps_next;
            ta_stage_reg  <= soft_reset ? 1'b0 : ta_stage_next;
            ta_open_reg   <= soft_reset ? 3'h0 : ta_open_next;
            wd_cnt_reg    <= wd_cnt_next;
            grace_reg     <= grace_next;
            grace_cnt_reg <= grace_cnt_next;
        end
    end

    // configuration byte and interrupt enables
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cfg_reg <= `WDRT_CFG_RESET;
            ien_reg <= 1'b0;
            gie_reg <= 1'b0;
        end
        else if (soft_reset)
        begin
            ien_reg <= 1'b0;
            gie_reg <= 1'b0;
        end
        else if (i_wr)
        begin
            if (i_addr == `WDRT_ADDR_CFG)
                cfg_reg <= i_wdata;
            if (i_addr == `WDRT_ADDR_IEN)
                ien_reg <= i_wdata[`WDRT_IEN_BIT];
            if (i_addr == `WDRT_ADDR_GIE)
                gie_reg <= i_wdata[`WDRT_GIE_BIT];
        end
    end

    // read data, one cycle after the read strobe
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rdata_reg <= 8'h00;
        else if (i_rd)
        begin
            case (i_addr)
                `WDRT_ADDR_CTL: rdata_reg <= ctl_read;
                `WDRT_ADDR_CFG: rdata_reg <= cfg_reg;
                `WDRT_ADDR_IEN: rdata_reg <= {3'h0, ien_reg, 4'h0};
                `WDRT_ADDR_GIE: rdata_reg <= {gie_reg, 7'h00};
                `WDRT_ADDR_TA:  rdata_reg <= 8'h00;
                default:        rdata_reg <= 8'h00;
            endcase
        end
        else
            rdata_reg <= 8'h00;
    end

    // event outputs
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wd_reset_reg <= 1'b0;
            wake_reg     <= 1'b0;
            irq_reg      <= 1'b0;
        end
        else
        begin
            wd_reset_reg <= grace_done & ~soft_reset;
            wake_reg     <= timeout_evt;
            irq_reg      <= tf_next & ien_reg & gie_reg & ~soft_reset;
        end
    end

    assign o_rdata    = rdata_reg;
    assign o_wd_reset = wd_reset_reg;
    assign o_wake     = wake_reg;
    assign o_irq_req  = irq_reg;

endmodule

// ### sim/wdrt_timer_sva.sv
// port checker for the watchdog reset timer
`timescale 1ns/1ns
module wdrt_checker
#(
    parameter [15:0] OSC_TICK_CYC = 16'h0004
)
(
    input wire       i_clk,
    input wire       i_reset_n,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire       i_lowpower,
    input wire       i_other_reset,
    input wire [7:0] o_rdata,
    input wire       o_wd_reset,
    input wire       o_wake,
    input wire       o_irq_req
);
    reg  [7:0]  cfg_reg;
    reg         ien_reg;
    reg         gie_reg;
    reg  [15:0] since_reg;
    reg         armed_reg;
    wire        lp5 = i_lowpower && (cfg_reg[7:4] == 4'h5);
    // mirror of config and enables, cycles since the wake opening grace
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cfg_reg   <= 8'hFF;
            ien_reg   <= 1'b0;
            gie_reg   <= 1'b0;
            since_reg <= 16'h0000;
            armed_reg <= 1'b0;
        end
        else
        begin
            if (i_wr && i_addr == 8'h01)
                cfg_reg <= i_wdata;
            if (i_other_reset || o_wd_reset)
            begin
                ien_reg <= 1'b0;
                gie_reg <= 1'b0;
            end
            else if (i_wr && i_addr == 8'h02)
                ien_reg <= i_wdata[4];
            else if (i_wr && i_addr == 8'h03)
                gie_reg <= i_wdata[7];
            // later wakes inside an open grace window do not restart it
            if (i_other_reset || o_wd_reset || cfg_reg[7:4] == 4'hF ||
                (i_wr && i_addr == 8'h00 && i_wdata[6]))
                armed_reg <= 1'b0;
            else if (o_wake)
                armed_reg <= 1'b1;
            if (o_wake && !armed_reg)
                since_reg <= 16'h0000;
            else if (since_reg != 16'hFFFF)
                since_reg <= since_reg + 16'h0001;
        end
    end
    default clocking dcb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wake_pulse_a: assert property (o_wake |=> !o_wake)
        else $error("wake longer than one cycle");
    wdreset_pulse_a: assert property (o_wd_reset |=> !o_wd_reset)
        else $error("watchdog reset longer than one cycle");
    grace_len_a: assert property (o_wd_reset |-> since_reg + 1 >= 512 * OSC_TICK_CYC)
        else $error("watchdog reset before grace ended");
    gp_noreset_a: assert property (o_wd_reset |-> $past(cfg_reg[7:4]) != 4'hF)
        else $error("watchdog reset in timer mode");
    lp_halt_a: assert property (o_wake |-> !($past(lp5) && $past(lp5, 2)))
        else $error("wake while halted in low power");
    irq_enable_a: assert property (o_irq_req |-> $past(ien_reg) && $past(gie_reg))
        else $error("irq without both enables");
    irq_follow_a: assert property (o_wake && $past(ien_reg) && $past(gie_reg) |-> o_irq_req)
        else $error("no irq on enabled time-out");
    cfg_read_a: assert property ($past(i_rd) && $past(i_addr) == 8'h01 |-> o_rdata == $past(cfg_reg))
        else $error("config read mismatch");
    key_read_a: assert property ($past(i_rd) && $past(i_addr) >= 8'h04 |-> o_rdata == 8'h00)
        else $error("key or unmapped read not zero");
    cover property (o_wd_reset);
    cover property (o_wake && o_irq_req);
    cover property (o_wake && i_lowpower);
endmodule

// ### sim/tb.sv
// self-checking bench for the watchdog reset timer
`timescale 1ns/1ns
module tb;
    localparam [15:0] P = 16'h0004;
    reg        i_clk = 1'b0;
    reg        i_reset_n = 1'b0;
    reg  [7:0] i_addr = 8'h00;
    reg  [7:0] i_wdata = 8'h00;
    reg        i_wr = 1'b0;
    reg        i_rd = 1'b0;
    reg        i_lowpower = 1'b0;
    reg        i_other_reset = 1'b0;
    wire [7:0] o_rdata;
    wire       o_wd_reset;
    wire       o_wake;
    wire       o_irq_req;
    int        failures = 0;
    int        checked = 0;
    int        seed = 73;
    int        n;
    reg        rd_d = 1'b0;
    reg [15:0] exp_q[$];
    reg [15:0] e;
    reg [3:0]  code;
    wdrt_timer #(.OSC_TICK_CYC(P)) DUT
    (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_lowpower(i_lowpower), .i_other_reset(i_other_reset),
        .o_rdata(o_rdata), .o_wd_reset(o_wd_reset), .o_wake(o_wake), .o_irq_req(o_irq_req)
    );
    always #2 i_clk = ~i_clk;
    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
    endtask
    task idle;
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        @(posedge i_clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        idle;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back({a, x});
        bus(1'b0, a, 8'h00);
        idle;
    endtask
    // unlock then write control
    task ta_wr(input logic [7:0] d);
        bus(1'b1, 8'h04, 8'hAA);
        bus(1'b1, 8'h04, 8'h55);
        bus(1'b1, 8'h00, d);
        idle;
    endtask
    task wait_sig(input bit rst, input int lim);
        n = 0;
        while (n < lim)
        begin
            @(posedge i_clk);
            n++;
            if ((rst ? o_wd_reset : o_wake) === 1'b1)
                break;
        end
    endtask
    always @(posedge i_clk)
    begin
        rd_d <= i_rd;
        if (rd_d)
        begin
            e = exp_q.pop_front();
            check("rdata", {8'h00, o_rdata}, {8'h00, e[7:0]});
        end
    end
    initial
    begin
        #320000;
        failures++;
        report_and_stop;
    end
    initial
    begin
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        rd(8'h00, 8'h07);
        rd(8'h01, 8'hFF);
        rd(8'h02, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'h00, 8'h80);
        wr(8'h04, 8'hAA);
        wr(8'h02, 8'h00);
        wr(8'h04, 8'h55);
        wr(8'h00, 8'h80);
        rd(8'h00, 8'h07);
        $display("test reset and lock done");
        wr(8'h02, 8'h10);
        wr(8'h03, 8'h80);
        for (int ps = 0; ps < 5; ps++)
        begin
            ta_wr(8'hC0 | ps[7:0]);
            wait_sig(1'b0, 20000);
            wait_sig(1'b0, 40000);
            check("period", n[15:0], (16'h0040 * P) << (ps == 0 ? 0 : ps + 1));
            check("irq", {15'h0000, o_irq_req}, 16'h0001);
        end
        rd(8'h00, 8'hA4);
        $display("test prescale done");
        i_lowpower <= 1'b1;
        ta_wr(8'hC0);
        wait_sig(1'b0, 600);
        check("lp stop", n[15:0], 16'h0258);
        ta_wr(8'hD0);
        wait_sig(1'b0, 600);
        check("lp run", {15'h0000, n < 600}, 16'h0001);
        ta_wr(8'h00);
        wait_sig(1'b0, 600);
        check("run off", n[15:0], 16'h0258);
        $display("test timer mode done");
        n = $random(seed);
        code = {2'b00, n[1:0]};
        wr(8'h01, {code, 4'h0});
        wait_sig(1'b0, 400);
        check("reset mode", {15'h0000, n < 400}, 16'h0001);
        bus(1'b1, 8'h04, 8'hAA);
        bus(1'b1, 8'h04, 8'h55);
        bus(1'b1, 8'h00, 8'h40);
        rd(8'h00, 8'h40);
        i_lowpower <= 1'b0;
        repeat (2 * P) @(posedge i_clk);
        rd(8'h00, 8'h00);
        wait_sig(1'b0, 400);
        wait_sig(1'b1, 3000);
        check("grace", n[15:0], 16'h0200 * P);
        rd(8'h00, 8'h08);
        rd(8'h02, 8'h00);
        rd(8'h01, {code, 4'h0});
        wait_sig(1'b0, 400);
        check("auto start", {15'h0000, n < 400}, 16'h0001);
        $display("test reset mode done");
        ta_wr(8'h0B);
        i_other_reset <= 1'b1;
        @(posedge i_clk);
        i_other_reset <= 1'b0;
        rd(8'h00, 8'h0B);
        ta_wr(8'h03);
        rd(8'h00, 8'h03);
        $display("test other reset done");
        wr(8'h01, 8'h50);
        i_lowpower <= 1'b1;
        ta_wr(8'h40);
        wait_sig(1'b0, 600);
        check("halt lp", n[15:0], 16'h0258);
        i_lowpower <= 1'b0;
        wait_sig(1'b0, 400);
        check("run awake", {15'h0000, n < 400}, 16'h0001);
        $display("test halt mode done");
        report_and_stop;
    end
endmodule
bind wdrt_timer wdrt_checker #(.OSC_TICK_CYC(OSC_TICK_CYC)) u_chk
(
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_lowpower(i_lowpower), .i_other_reset(i_other_reset),
    .o_rdata(o_rdata), .o_wd_reset(o_wd_reset), .o_wake(o_wake), .o_irq_req(o_irq_req)
);
